// ---- src/debug_monitor_pkg.sv ----
// constants shared by the debug monitor register set
package debug_monitor_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] instr_addr = 16'hff00;
  localparam logic [15:0] status_addr = 16'hff01;
  localparam logic [15:0] shifter_hi_addr = 16'hff02;
  localparam logic [15:0] shifter_lo_addr = 16'hff03;
  localparam logic [15:0] addr_hi_addr = 16'hff04;
  localparam logic [15:0] addr_lo_addr = 16'hff05;
  localparam logic [15:0] ccr_addr = 16'hff06;
  localparam logic [7:0] map_base_hi = 8'hff;
  localparam logic [7:0] reg_hi_limit = 8'h06;
  // ****************************************
  // instruction fields
  // ****************************************
  localparam int hw_flag_bit = 7;
  localparam int data_flag_bit = 6;
  localparam int read_flag_bit = 5;
  localparam int bg_req_bit = 4;
  localparam int word_bit = 3;
  localparam int map_sel_bit = 2;
  localparam logic [7:0] bg_cmd_value = 8'h90;
  localparam logic [1:0] go_resume = 2'h1;
  localparam logic [1:0] go_step = 2'h2;
  localparam logic [1:0] go_tag = 2'h3;
  localparam logic [2:0] reg_next = 3'h2;
  localparam logic [2:0] reg_pc = 3'h3;
  localparam logic [2:0] reg_d = 3'h4;
  localparam logic [2:0] reg_x = 3'h5;
  localparam logic [2:0] reg_y = 3'h6;
  localparam logic [2:0] reg_sp = 3'h7;
  localparam logic [15:0] next_step = 16'h0002;
  // ****************************************
  // status fields and reset values
  // ****************************************
  localparam int enable_bit = 7;
  localparam int active_bit = 6;
  localparam int tag_bit = 5;
  localparam int valid_bit = 4;
  localparam int step_bit = 3;
  localparam logic [7:0] instr_reset = 8'h00;
  localparam logic [7:0] status_reset = 8'h00;
  // ****************************************
  // timing
  // ****************************************
  localparam int idle_edge_cycles = 512;
  localparam logic [9:0] idle_limit = 10'(idle_edge_cycles - 1);
  localparam int active_delay_cycles = 4;
  localparam int tag_delay_cycles = 16;
  localparam int clk_period_ns = 8;
  localparam logic [3:0] tag_limit = 4'(tag_delay_cycles - 1);
  localparam logic [7:0] zero_byte = 8'h00;
endpackage

// ---- src/debug_delay_line.sv ----
// fixed-length delay line for a one-bit value
`timescale 1ns/100ps
module debug_delay_line
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  input wire logic init_in,
  output logic q_out
);
  logic [debug_monitor_pkg::active_delay_cycles-1:0] pipe;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pipe <= '0;
    else if (init_in)
      pipe <= '1;
    else
      pipe <= {pipe[debug_monitor_pkg::active_delay_cycles-2:0], d_in};
  end

  assign q_out = pipe[debug_monitor_pkg::active_delay_cycles-1];
endmodule

// ---- src/debug_monitor_register_set.sv ----
// debug monitor register set: instruction, status, shifter, address holder, saved codes
// What this block does
// R1 - seven byte registers at ff00..ff06, mapped only while debug is active
// R2 - instruction register clears after 512 cycles between host falling edges
// R3 - instruction loads from serial bits; also readable and writable on the bus
// R4 - hardware decode: class, data, read, enter request, word, map select
// R5 - enter request set only for instruction value 90
// R6 - map select picks debug map or user map for hardware accesses
// R7 - firmware bits 4:3: none, resume, single step, tag and resume
// R8 - firmware bits 2:0 select next, pc, d, x, y or sp
// R9 - register codes 000 and 001 select nothing and access nothing
// R10 - next-word commands add 2 to x before the access
// R11 - status bits: enable, active, tagging, shifter valid, step; low bits zero
// R12 - special modes reset active to 1; other modes reset all to 0
// R13 - enable low refuses debug entry but hardware commands still run
// R14 - active set on entry maps resources; firmware store clears it
// R15 - writes to the active bit take effect five cycles later
// R16 - host must not clear the active bit with a next-word write
// R17 - tag-resume sets tagging; serial ignored 16 cycles later; entry clears
// R18 - shifter valid shows that the shifter holds valid data
// R19 - single-step command sets the step flag
// R20 - 16-bit shifter holds serial data, readable and writable while debug is active
// R21 - address holder written only by debug hardware, readable while debug is active
// R22 - saved codes take user condition codes on debug entry
// R23 - host writes saved codes only during active debug
// R24 - host waits about 150 cycles between hardware commands
`timescale 1ns/100ps
module debug_monitor_register_set
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // operating mode, sampled after reset release
  input wire logic special_mode_in,
  // parallel bus
  input wire logic [15:0] bus_addr_in,
  input wire logic bus_rd_in,
  input wire logic bus_wr_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  output logic bus_hit_out,
  // serial engine side
  input wire logic host_fall_in,
  input wire logic serial_bit_valid_in,
  input wire logic serial_bit_in,
  input wire logic instr_done_in,
  input wire logic shift_load_in,
  input wire logic [15:0] shift_data_in,
  input wire logic addr_load_in,
  input wire logic [15:0] addr_data_in,
  // core side
  input wire logic enter_in,
  input wire logic [7:0] user_ccr_in,
  input wire logic [15:0] x_index_in,
  input wire logic fw_exec_in,
  output logic [7:0] instr_out,
  output logic hw_cmd_out,
  output logic data_follows_out,
  output logic read_cmd_out,
  output logic enter_debug_request_out,
  output logic word_size_out,
  output logic map_select_flag_out,
  output logic resume_out,
  output logic single_step_out,
  output logic tag_resume_out,
  output logic [2:0] target_register_field_out,
  output logic reg_access_out,
  output logic [15:0] next_x_out,
  output logic entry_allowed_out,
  output logic debug_map_out,
  output logic tagging_out,
  output logic serial_enable_out
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] instr;
  logic enable, active, tagging_enable, shifter_valid, step;
  logic [15:0] shifter, address_holder;
  logic [7:0] saved_condition_codes;
  logic [9:0] idle_count;
  logic [3:0] tag_count;
  logic tag_live, mode_sampled, active_delayed, active_req;
  // ****************************************
  // decode
  // ****************************************
  function automatic logic sel(input logic [15:0] a, input logic [15:0] r);
    return a == r;
  endfunction
  wire in_map = active; // R1
  wire wr_instr = bus_wr_in && in_map && sel(bus_addr_in, debug_monitor_pkg::instr_addr);
  wire wr_status = bus_wr_in && in_map && sel(bus_addr_in, debug_monitor_pkg::status_addr);
  wire wr_sh_hi = bus_wr_in && in_map && sel(bus_addr_in, debug_monitor_pkg::shifter_hi_addr);
  wire wr_sh_lo = bus_wr_in && in_map && sel(bus_addr_in, debug_monitor_pkg::shifter_lo_addr);
  wire wr_ccr = bus_wr_in && in_map && sel(bus_addr_in, debug_monitor_pkg::ccr_addr);
  wire hit = in_map && bus_addr_in[15:8] == debug_monitor_pkg::map_base_hi
    && bus_addr_in[7:0] <= debug_monitor_pkg::reg_hi_limit; // R1
  wire [7:0] status_byte = {enable, active, tagging_enable, shifter_valid, step, 3'h0}; // R11
  wire serial_en = !tag_live; // R17
  wire is_hw = instr[debug_monitor_pkg::hw_flag_bit]; // R4
  wire [1:0] go_field = instr[4:3]; // R7
  wire [2:0] reg_field = instr[2:0]; // R8
  wire fw_cmd = fw_exec_in && !is_hw && enable; // R13
  wire do_step = fw_cmd && go_field == debug_monitor_pkg::go_step; // R7
  wire do_tag = fw_cmd && go_field == debug_monitor_pkg::go_tag; // R7
  wire do_entry = enter_in && enable && !active; // R13
  wire idle_expired = idle_count == debug_monitor_pkg::idle_limit; // R2
  wire tag_expired = tag_count == debug_monitor_pkg::tag_limit;
  wire [7:0] next_instr =
    wr_instr ? bus_wdata_in :
    (serial_bit_valid_in && serial_en) ? {instr[6:0], serial_bit_in} : instr; // R3
  wire [7:0] rd_mux =
    sel(bus_addr_in, debug_monitor_pkg::instr_addr) ? instr :
    sel(bus_addr_in, debug_monitor_pkg::status_addr) ? status_byte :
    sel(bus_addr_in, debug_monitor_pkg::shifter_hi_addr) ? shifter[15:8] : // R20
    sel(bus_addr_in, debug_monitor_pkg::shifter_lo_addr) ? shifter[7:0] :
    sel(bus_addr_in, debug_monitor_pkg::addr_hi_addr) ? address_holder[15:8] : // R21
    sel(bus_addr_in, debug_monitor_pkg::addr_lo_addr) ? address_holder[7:0] :
    sel(bus_addr_in, debug_monitor_pkg::ccr_addr) ? saved_condition_codes :
    debug_monitor_pkg::zero_byte;
  // ****************************************
  // instruction register and idle timer
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      idle_count <= '0;
    else if (host_fall_in || idle_expired)
      idle_count <= '0;
    else
      idle_count <= idle_count + 10'h001;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      instr <= debug_monitor_pkg::instr_reset;
    else if (idle_expired && !host_fall_in && !wr_instr)
      instr <= debug_monitor_pkg::instr_reset; // R2
    else
      instr <= next_instr; // R3
  end
  // ****************************************
  // status register
  // ****************************************
  // mode strap is caught one edge after release, never under the async reset
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      mode_sampled <= 1'b0;
    else
      mode_sampled <= 1'b1;
  end
  wire strap_load = !mode_sampled;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      active_req <= 1'b0;
    else if (strap_load)
      active_req <= special_mode_in;
    else if (do_entry)
      active_req <= 1'b1;
    else if (wr_status)
      active_req <= bus_wdata_in[debug_monitor_pkg::active_bit]; // R15
  end
  // request is held, not taken from active, so a cleared bit cannot circulate
  debug_delay_line active_delay
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in(active_req),
    .init_in(do_entry || (strap_load && special_mode_in)),
    .q_out(active_delayed)
  );
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      enable <= 1'b0;
      active <= 1'b0;
      tagging_enable <= 1'b0;
      step <= 1'b0;
    end
    else
    begin
      if (strap_load)
        active <= special_mode_in; // R12
      else if (do_entry)
        active <= 1'b1; // R14
      else
        active <= active_delayed; // R15
      if (wr_status)
        enable <= bus_wdata_in[debug_monitor_pkg::enable_bit];
      if (do_entry)
        tagging_enable <= 1'b0; // R17
      else if (do_tag)
        tagging_enable <= 1'b1; // R17
      else if (wr_status)
        tagging_enable <= bus_wdata_in[debug_monitor_pkg::tag_bit];
      if (do_step)
        step <= 1'b1; // R19
      else if (wr_status)
        step <= bus_wdata_in[debug_monitor_pkg::step_bit];
    end
  end
  // tagging goes live 16 cycles after the enable bit is written
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tag_count <= '0;
    else if (!tagging_enable || tag_live)
      tag_count <= '0;
    else
      tag_count <= tag_count + 4'h1;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tag_live <= 1'b0;
    else
      tag_live <= tagging_enable && (tag_live || tag_expired); // R17
  end
  // ****************************************
  // shifter, address holder, saved codes
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shifter <= '0;
      shifter_valid <= 1'b0;
      address_holder <= '0;
      saved_condition_codes <= '0;
    end
    else
    begin
      if (shift_load_in)
        shifter <= shift_data_in; // R20
      else if (wr_sh_hi)
        shifter[15:8] <= bus_wdata_in;
      else if (wr_sh_lo)
        shifter[7:0] <= bus_wdata_in;
      if (shift_load_in)
        shifter_valid <= 1'b1; // R18
      else if (wr_status)
        shifter_valid <= bus_wdata_in[debug_monitor_pkg::valid_bit];
      if (addr_load_in)
        address_holder <= addr_data_in; // R21
      if (do_entry)
        saved_condition_codes <= user_ccr_in; // R22
      else if (wr_ccr)
        saved_condition_codes <= bus_wdata_in;
    end
  end
  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus_rdata_out <= '0;
      bus_hit_out <= 1'b0;
      instr_out <= '0;
      hw_cmd_out <= 1'b0;
      data_follows_out <= 1'b0;
      read_cmd_out <= 1'b0;
      enter_debug_request_out <= 1'b0;
      word_size_out <= 1'b0;
      map_select_flag_out <= 1'b0;
      resume_out <= 1'b0;
      single_step_out <= 1'b0;
      tag_resume_out <= 1'b0;
      target_register_field_out <= '0;
      reg_access_out <= 1'b0;
      next_x_out <= '0;
      entry_allowed_out <= 1'b0;
      debug_map_out <= 1'b0;
      tagging_out <= 1'b0;
      serial_enable_out <= 1'b0;
    end
    else
    begin
      bus_rdata_out <= (bus_rd_in && hit) ? rd_mux : debug_monitor_pkg::zero_byte;
      bus_hit_out <= (bus_rd_in || bus_wr_in) && hit;
      instr_out <= instr;
      hw_cmd_out <= is_hw; // R4
      data_follows_out <= instr[debug_monitor_pkg::data_flag_bit];
      read_cmd_out <= instr[debug_monitor_pkg::read_flag_bit];
      enter_debug_request_out <= is_hw && instr == debug_monitor_pkg::bg_cmd_value; // R5
      word_size_out <= is_hw && instr[debug_monitor_pkg::word_bit];
      // map select only steers hardware reads and writes
      map_select_flag_out <= is_hw && instr[debug_monitor_pkg::data_flag_bit]
        && instr[debug_monitor_pkg::map_sel_bit]; // R6
      resume_out <= fw_cmd && go_field == debug_monitor_pkg::go_resume; // R7
      single_step_out <= do_step;
      tag_resume_out <= do_tag;
      target_register_field_out <= is_hw ? 3'h0 : reg_field; // R8
      reg_access_out <= fw_cmd && reg_field >= debug_monitor_pkg::reg_next; // R9
      next_x_out <= x_index_in + debug_monitor_pkg::next_step; // R10
      entry_allowed_out <= enable; // R13
      debug_map_out <= active; // R14
      tagging_out <= tag_live;
      serial_enable_out <= serial_en;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  sequence write_active_clear;
    wr_status && !bus_wdata_in[debug_monitor_pkg::active_bit] && active && !do_entry;
  endsequence
  chk_unmapped_silent: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R1
    !active |=> !bus_hit_out) else $error("register hit while unmapped");
  chk_idle_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R2
    idle_expired && !host_fall_in && !wr_instr |=> instr == 8'h00)
    else $error("instruction not cleared after idle");
  chk_bg_decode: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R5
    enter_debug_request_out |-> $past(instr) == 8'h90) else $error("wrong enter request");
  chk_empty_reg_field: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R9
    fw_cmd && reg_field < 3'h2 |=> !reg_access_out) else $error("access on empty register code");
  chk_next_add_two: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R10
    1'b1 |=> next_x_out == $past(x_index_in) + 16'h0002)
    else $error("next address not x plus two");
  chk_active_delay: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R15
    write_active_clear ##1 (!do_entry && !strap_load)[*4] |=> ##1 !active)
    else $error("active write delay wrong");
  chk_active_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R15
    write_active_clear |=> active) else $error("active cleared too early");
  chk_entry_refused: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R13
    enter_in && !enable && !active && mode_sampled && !active_delayed |=> !active)
    else $error("entry with enable low");
  chk_tag_serial: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R17
    tagging_enable && !$past(tagging_enable) |-> ##[16:17] !serial_en or ##[0:16] !tagging_enable)
    else $error("tagging not live after 16 cycles");
  chk_step_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R19
    do_step |=> step) else $error("step flag not set");
  chk_entry_ccr: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R22
    do_entry |=> saved_condition_codes == $past(user_ccr_in) && active)
    else $error("entry state wrong");
endmodule

// ---- sim/debug_host_model.sv ----
// behavioural debug host that shifts command bytes onto the one-wire pin
`timescale 1ns/100ps
module debug_host_model
#(
  parameter int gap_cycles = 2,
  parameter int settle_cycles = 150
)
(
  input wire logic mclk_in,
  output logic host_fall_out,
  output logic bit_valid_out,
  output logic bit_out
);
  initial
  begin
    host_fall_out = 1'b0;
    bit_valid_out = 1'b0;
    bit_out = 1'b1;
  end
  // ****************************************
  // command byte, msb first
  // ****************************************
  // only command bytes go out; they write only the instruction register, also while debug runs
  task automatic send_byte(input logic [7:0] cmd);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge mclk_in);
      #1;
      host_fall_out = 1'b1;
      @(posedge mclk_in);
      #1;
      host_fall_out = 1'b0;
      repeat (gap_cycles) @(posedge mclk_in);
      #1;
      bit_valid_out = 1'b1;
      bit_out = cmd[i];
      @(posedge mclk_in);
      #1;
      bit_valid_out = 1'b0;
      // stale data is inverted so a late sample cannot pass by luck
      bit_out = ~cmd[i];
    end
    // give the command time to finish before anything else happens
    repeat (settle_cycles) @(posedge mclk_in);
    #1;
  endtask
endmodule

// ---- sim/tb_debug_monitor_register_set.sv ----
// self-checking bench for the debug monitor register set
`timescale 1ns/100ps
module tb_debug_monitor_register_set;
  logic mclk_in;
  logic rst_n_in;
  logic special_mode_in;
  logic [15:0] bus_addr_in;
  logic bus_rd_in;
  logic bus_wr_in;
  logic [7:0] bus_wdata_in;
  logic [7:0] bus_rdata_out;
  logic bus_hit_out;
  wire host_fall_in, serial_bit_valid_in, serial_bit_in;
  wire fw_exec_in, enter_in, shift_load_in, addr_load_in;
  logic instr_done_in;
  logic [15:0] shift_data_in, addr_data_in, x_index_in, next_x_out, v, e;
  logic [7:0] user_ccr_in, instr_out, rdata, c;
  logic [3:0] pls;
  logic hw_cmd_out, data_follows_out, read_cmd_out, enter_debug_request_out;
  logic word_size_out, map_select_flag_out, resume_out, single_step_out, tag_resume_out;
  logic [2:0] target_register_field_out;
  logic reg_access_out, entry_allowed_out, debug_map_out, tagging_out, serial_enable_out;
  logic rhit;
  int bad_count;
  int check_count;
  logic [7:0] hw_cmds [6] = '{8'h90, 8'he4, 8'hec, 8'he0, 8'hc8, 8'hc4};

  assign {fw_exec_in, enter_in, shift_load_in, addr_load_in} = pls;

  debug_monitor_register_set debug_monitor_register_set_inst
  (
    .mclk_in, .rst_n_in, .special_mode_in, .bus_addr_in, .bus_rd_in, .bus_wr_in,
    .bus_wdata_in, .bus_rdata_out, .bus_hit_out, .host_fall_in, .serial_bit_valid_in,
    .serial_bit_in, .instr_done_in, .shift_load_in, .shift_data_in, .addr_load_in,
    .addr_data_in, .enter_in, .user_ccr_in, .x_index_in, .fw_exec_in, .instr_out,
    .hw_cmd_out, .data_follows_out, .read_cmd_out, .enter_debug_request_out,
    .word_size_out, .map_select_flag_out, .resume_out, .single_step_out, .tag_resume_out,
    .target_register_field_out, .reg_access_out, .next_x_out, .entry_allowed_out,
    .debug_map_out, .tagging_out, .serial_enable_out
  );

  debug_host_model debug_host_model_inst
  (
    .mclk_in,
    .host_fall_out(host_fall_in),
    .bit_valid_out(serial_bit_valid_in),
    .bit_out(serial_bit_in)
  );

  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic pulse(input logic [3:0] p);
    cyc(1);
    pls = p;
    cyc(1);
    pls = 4'h0;
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    bus_addr_in = a;
    bus_wdata_in = d;
    bus_wr_in = 1'b1;
    cyc(1);
    bus_wr_in = 1'b0;
  endtask

  // read data and hit are registered, so they are taken one edge after the request
  task automatic bus_rd(input logic [15:0] a);
    cyc(1);
    bus_addr_in = a;
    bus_rd_in = 1'b1;
    cyc(1);
    bus_rd_in = 1'b0;
    rdata = bus_rdata_out;
    rhit = bus_hit_out;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input string what, input logic [15:0] a, input logic h,
                      input logic [7:0] d);
    bus_rd(a);
    check(what, {7'h00, rhit, rdata}, {7'h00, h, d});
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    rst_n_in = 1'b0;
    special_mode_in = 1'b1;
    bus_addr_in = 16'h0000;
    bus_rd_in = 1'b0;
    bus_wr_in = 1'b0;
    bus_wdata_in = 8'h00;
    instr_done_in = 1'b0;
    shift_data_in = 16'hbeef;
    addr_data_in = 16'h1234;
    user_ccr_in = 8'h5a;
    x_index_in = 16'hfffe;
    pls = 4'h0;
    bad_count = 0;
    check_count = 0;
    cyc(8);
    rst_n_in = 1'b1;
    cyc(3);
    check("map", 16'(debug_map_out), 16'h0001);
    rchk("instr", debug_monitor_pkg::instr_addr, 1'b1, 8'h00);
    rchk("status", debug_monitor_pkg::status_addr, 1'b1, 8'h40);
    rchk("unmapped", 16'hff07, 1'b0, 8'h00);
    done("reset");
    bus_wr(debug_monitor_pkg::status_addr, 8'hc7);
    rchk("status", debug_monitor_pkg::status_addr, 1'b1, 8'hc0);
    check("allow", 16'(entry_allowed_out), 16'h0001);
    pulse(4'h3);
    rchk("shift_hi", debug_monitor_pkg::shifter_hi_addr, 1'b1, 8'hbe);
    rchk("shift_lo", debug_monitor_pkg::shifter_lo_addr, 1'b1, 8'hef);
    rchk("status", debug_monitor_pkg::status_addr, 1'b1, 8'hd0);
    bus_wr(debug_monitor_pkg::addr_hi_addr, 8'haa);
    rchk("addr_hi", debug_monitor_pkg::addr_hi_addr, 1'b1, 8'h12);
    rchk("addr_lo", debug_monitor_pkg::addr_lo_addr, 1'b1, 8'h34);
    bus_wr(debug_monitor_pkg::shifter_hi_addr, 8'ha5);
    bus_wr(debug_monitor_pkg::shifter_lo_addr, 8'h5a);
    rchk("shift_hi", debug_monitor_pkg::shifter_hi_addr, 1'b1, 8'ha5);
    rchk("shift_lo", debug_monitor_pkg::shifter_lo_addr, 1'b1, 8'h5a);
    bus_wr(debug_monitor_pkg::ccr_addr, 8'h3c);
    rchk("ccr", debug_monitor_pkg::ccr_addr, 1'b1, 8'h3c);
    done("registers");
    foreach (hw_cmds[i])
    begin
      c = hw_cmds[i];
      bus_wr(debug_monitor_pkg::instr_addr, c);
      cyc(2);
      check("instr", 16'(instr_out), 16'(c));
      v = 16'({hw_cmd_out, data_follows_out, read_cmd_out, enter_debug_request_out,
               word_size_out, map_select_flag_out, target_register_field_out});
      e = 16'({c[7:5], c == 8'h90, c[3], c[7] & c[6] & c[2], 3'h0});
      check("hw_decode", v, e);
    end
    done("hardware");
    for (int f = 0; f < 8; f++)
    begin
      c = 8'h60 | 8'(f);
      bus_wr(debug_monitor_pkg::instr_addr, c);
      pulse(4'h8);
      v = 16'({target_register_field_out, reg_access_out, resume_out, single_step_out,
               tag_resume_out});
      e = 16'({c[2:0], f >= 2, 3'h0});
      check("fw_field", v, e);
      if (f == 2)
        check("next_x", next_x_out, 16'h0000);
    end
    for (int g = 1; g < 3; g++)
    begin
      c = 8'(g << 3);
      bus_wr(debug_monitor_pkg::instr_addr, c);
      pulse(4'h8);
      v = 16'({resume_out, single_step_out, tag_resume_out});
      check("go_field", v, 16'(3'b100 >> (g - 1)));
    end
    bus_rd(debug_monitor_pkg::status_addr);
    check("step", 16'(rdata & 8'he8), 16'h00c8);
    done("firmware");
    bus_wr(debug_monitor_pkg::status_addr, 8'h80);
    cyc(4);
    check("map", 16'(debug_map_out), 16'h0001);
    cyc(3);
    check("map", 16'(debug_map_out), 16'h0000);
    rchk("status", debug_monitor_pkg::status_addr, 1'b0, 8'h00);
    done("exit");
    // the bus is unmapped now, so the instruction can only arrive serially
    debug_host_model_inst.send_byte(8'h18);
    check("instr", 16'(instr_out), 16'h0018);
    pulse(4'h8);
    check("tag_go", 16'(tag_resume_out), 16'h0001);
    cyc(10);
    check("serial_on", 16'({tagging_out, serial_enable_out}), 16'h0001);
    cyc(10);
    check("serial_off", 16'({tagging_out, serial_enable_out}), 16'h0002);
    debug_host_model_inst.send_byte(8'h62);
    check("instr", 16'(instr_out), 16'h0018);
    pulse(4'h4);
    cyc(2);
    check("entry", 16'({debug_map_out, tagging_out}), 16'h0002);
    rchk("ccr", debug_monitor_pkg::ccr_addr, 1'b1, 8'h5a);
    bus_rd(debug_monitor_pkg::status_addr);
    check("status", 16'(rdata & 8'h60), 16'h0040);
    done("tagging");
    debug_host_model_inst.send_byte(8'h65);
    check("instr", 16'(instr_out), 16'h0065);
    cyc(330);
    check("instr", 16'(instr_out), 16'h0065);
    cyc(40);
    check("instr", 16'(instr_out), 16'h0000);
    done("idle");
    special_mode_in = 1'b0;
    rst_n_in = 1'b0;
    cyc(8);
    rst_n_in = 1'b1;
    cyc(3);
    check("plain", 16'({debug_map_out, entry_allowed_out}), 16'h0000);
    rchk("status", debug_monitor_pkg::status_addr, 1'b0, 8'h00);
    pulse(4'h4);
    cyc(2);
    check("refuse", 16'(debug_map_out), 16'h0000);
    debug_host_model_inst.send_byte(8'h90);
    check("bg_req", 16'({hw_cmd_out, enter_debug_request_out}), 16'h0003);
    done("plain_mode");
    results();
  end

  // the whole run needs about 1300 cycles; this margin only catches a hang
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    results();
  end
endmodule
